/* pcxrf_defines.svh */
// Offsets, field positions, reset values and sizes for the read forwarding block
`ifndef PCXRF_DEFINES_SVH
`define PCXRF_DEFINES_SVH
`define PCXRF_BUF_OFFSET   8'h40
`define PCXRF_BUF_RESET    32'h0160_2160
`define PCXRF_MR_SEC       25:24
`define PCXRF_MRL_SEC      23:22
`define PCXRF_MRM_SEC      21:20
`define PCXRF_MAXB         14:12
`define PCXRF_MR_PRI       9:8
`define PCXRF_MRL_PRI      7:6
`define PCXRF_MRM_PRI      5:4
`define PCXRF_PF_DWORD     2'h0
`define PCXRF_PF_LINE      2'h1
`define PCXRF_MAXB_BASE    13'h0080
`define PCXRF_BUF_BYTES    13'h0200
`define PCXRF_SECTOR       13'h0080
`define PCXRF_WORD         13'h0004
`define PCXRF_BIG_COMMIT   16'h8000
`define PCXRF_MB_SPAN      21'h10_0000
`define PCXRF_BE_ALL       4'h0
`define PCXRF_DATA_W       32
`define PCXRF_FIFO_DEPTH   16
`endif

/* pcxrf_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module pcxrf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = count_reg != (AW+1)'(DEPTH);
  assign out_valid = count_reg != '0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rptr_reg];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* pcxrf_pkg.sv */
// Types shared by the read forwarding block
package pcxrf_pkg;
  typedef enum logic [3:0] {
    PCXRF_MR, PCXRF_MRL, PCXRF_MRM, PCXRF_MRD, PCXRF_MRB,
    PCXRF_IOR, PCXRF_CFG0, PCXRF_CFG1
  } pcxrf_cmd_type;

  typedef enum logic [1:0] {
    PCXRF_DELAYED, PCXRF_SPLIT, PCXRF_IMMEDIATE, PCXRF_REJECT
  } pcxrf_hnd_type;

  typedef struct packed {
    logic          side_sec;
    logic          orig_pcix;
    logic          dest_pcix;
    logic          prefetchable;
    pcxrf_cmd_type cmd;
    logic [31:0]   addr;
    logic [12:0]   bcnt;
    logic [3:0]    be_n;
  } pcxrf_req_type;

  typedef struct packed {
    pcxrf_cmd_type cmd;
    logic [31:0]   addr;
    logic [12:0]   bcnt;
    logic [3:0]    be_n;
  } pcxrf_tgt_type;
endpackage

/* pcxrf_read_fwd.sv */
// Read forwarding engine: decode, command translation, fetch sizing, data path
`timescale 1ns/100ps
`include "pcxrf_defines.svh"

// Notes on behaviour
// - Memory reads are delayed from a conventional origin, split from a PCI-X origin.
// - PCI-X to PCI-X passes command; split capacity and commitment limit size requests.
// - Conventional to conventional non-prefetchable memory read fetches one DWORD only.
// - Memory read prefetch mode from bits 25:24 secondary, 9:8 primary; default one line.
// - Memory read line mode from bits 23:22 secondary, 7:6 primary; default one line.
// - Memory read multiple mode from 21:20 and 5:4; default full, capped by 14:12.
// - Maximum read byte count field resets to 512 bytes, one whole buffer.
// - Conventional to PCI-X: non-prefetchable memory read becomes DWORD read, prefetchable block read.
// - Conventional to PCI-X: read line and read multiple become block reads.
// - Conventional to PCI-X request may exceed default but obeys commitment limit.
// - Conventional to PCI-X fetching stops at every 1MB address boundary.
// - PCI-X DWORD read goes to conventional PCI as plain memory read.
// - Block read becomes read, read line or read multiple by span and line.
// - After early target disconnect the read is reissued until the count is done.
// - Block reads pause when buffer full, resume once a DWORD frees; reissue after a disconnect waits for a 128-byte sector.
// - I/O read passes untranslated, one DWORD, split or delayed by origin mode.
// - Type 1 configuration reads only accepted on primary; split or delayed.
// - Type 0 configuration reads on primary return immediate data in any mode.
// - Type 0 configuration reads on secondary are split or delayed by mode.
// - Non-prefetchable reads request one DWORD and end after delivering it.
// - Non-prefetchable reads pass initiator byte enables to the target unchanged.
// - Non-prefetchable covers I/O, config, conventional non-prefetchable and DWORD reads.
// - Prefetchable reads assert all byte enables in every data phase.
// - Large conventional prefetch refills the buffer as 128-byte sectors empty.
module pcxrf_read_fwd (
  input  wire logic                         ref_clk,
  input  wire logic                         resetn,
  input  wire logic                         cfg_wr,
  input  wire logic                         cfg_rd,
  input  wire logic [7:0]                   cfg_addr,
  input  wire logic [3:0]                   cfg_be,
  input  wire logic [31:0]                  cfg_wdata,
  output logic [31:0]                       cfg_rdata,
  input  wire logic [7:0]                   cache_line_dw,
  input  wire logic [15:0]                  split_capacity,
  input  wire logic [15:0]                  split_commit,
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire pcxrf_pkg::pcxrf_req_type     req,
  output logic                              hnd_valid,
  output pcxrf_pkg::pcxrf_hnd_type          hnd,
  output logic                              orig_retry,
  output logic                              tgt_req_valid,
  input  wire logic                         tgt_req_ready,
  output pcxrf_pkg::pcxrf_tgt_type          tgt_req,
  input  wire logic                         tgt_dvalid,
  output logic                              tgt_dready,
  input  wire logic [`PCXRF_DATA_W-1:0]     tgt_data,
  input  wire logic                         tgt_done,
  output logic                              tgt_stop,
  output logic                              orig_dvalid,
  input  wire logic                         orig_dready,
  output logic [`PCXRF_DATA_W-1:0]          orig_data,
  output logic                              orig_last,
  output logic                              busy
);
  typedef enum logic [2:0] {
    PCXRF_IDLE, PCXRF_PLAN, PCXRF_ISSUE, PCXRF_FETCH, PCXRF_HOLD, PCXRF_DRAIN
  } pcxrf_state_type;

  pcxrf_state_type           state_reg;
  logic [31:0]               bufctl_reg;
  logic [31:0]               addr_reg;
  logic [12:0]               rem_reg;
  logic [12:0]               deliv_reg;
  logic [12:0]               credit_reg;
  logic [12:0]               chunk_reg;
  logic [12:0]               chunk_next;
  logic                      orig_pcix_reg;
  logic                      dest_pcix_reg;
  pcxrf_pkg::pcxrf_cmd_type  cmd_reg;
  logic [3:0]                be_reg;
  pcxrf_pkg::pcxrf_cmd_type  cmd_next;
  pcxrf_pkg::pcxrf_hnd_type  hnd_next;
  logic [12:0]               tot_next;
  logic                      nonpf;
  logic                      accept;
  logic                      tgt_take;
  logic                      orig_take;
  logic [12:0]               free_bytes;
  logic [1:0]                pf_mode;
  logic [9:0]                line_bytes;
  logic [9:0]                line_off;
  logic [14:0]               span;
  logic [20:0]               to_mb;
  logic                      fifo_in_ready;

  function automatic logic [12:0] min13(input logic [12:0] a, input logic [12:0] b);
    min13 = (a < b) ? a : b;
  endfunction

  // Clips a 16-bit limit to the 13-bit count range
  function automatic logic [12:0] lim13(input logic [15:0] v);
    lim13 = (v > 16'(13'h1FFF)) ? 13'h1FFF : v[12:0];
  endfunction

  assign accept     = (state_reg == PCXRF_IDLE) && req_valid;
  assign req_ready  = state_reg == PCXRF_IDLE;
  assign busy       = state_reg != PCXRF_IDLE;
  assign free_bytes = `PCXRF_BUF_BYTES - credit_reg;
  assign line_bytes = {cache_line_dw, 2'h0};
  assign line_off   = req.addr[9:0] & (line_bytes - 10'h001);
  assign span       = 15'(req.addr[1:0]) + 15'(req.bcnt);

  // Configuration space access to the buffering control register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bufctl_reg <= `PCXRF_BUF_RESET;
    end else if (cfg_wr && cfg_addr == `PCXRF_BUF_OFFSET) begin
      for (int i = 0; i < 4; i++) begin
        if (cfg_be[i]) begin
          bufctl_reg[i*8 +: 8] <= cfg_wdata[i*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_rd) begin
      cfg_rdata <= (cfg_addr == `PCXRF_BUF_OFFSET) ? bufctl_reg : 32'h0000_0000;
    end
  end

  // Request decode
  always_comb begin
    nonpf = (req.cmd == pcxrf_pkg::PCXRF_IOR) || (req.cmd == pcxrf_pkg::PCXRF_CFG0) ||
            (req.cmd == pcxrf_pkg::PCXRF_CFG1) || (req.cmd == pcxrf_pkg::PCXRF_MRD) ||
            (req.cmd == pcxrf_pkg::PCXRF_MR && !req.prefetchable && !req.orig_pcix);
    hnd_next = req.orig_pcix ? pcxrf_pkg::PCXRF_SPLIT : pcxrf_pkg::PCXRF_DELAYED;
    if (req.cmd == pcxrf_pkg::PCXRF_CFG0 && !req.side_sec) begin
      hnd_next = pcxrf_pkg::PCXRF_IMMEDIATE;
    end
    if (req.cmd == pcxrf_pkg::PCXRF_CFG1 && req.side_sec) begin
      hnd_next = pcxrf_pkg::PCXRF_REJECT;
    end
    cmd_next = req.cmd;
    if (req.orig_pcix && !req.dest_pcix) begin
      if (req.cmd == pcxrf_pkg::PCXRF_MRD) begin
        cmd_next = pcxrf_pkg::PCXRF_MR;
      end else if (req.cmd == pcxrf_pkg::PCXRF_MRB) begin
        if (span <= 15'(`PCXRF_WORD)) begin
          cmd_next = pcxrf_pkg::PCXRF_MR;
        end else if (15'(line_off) + 15'(req.bcnt) <= 15'(line_bytes)) begin
          cmd_next = pcxrf_pkg::PCXRF_MRL;
        end else begin
          cmd_next = pcxrf_pkg::PCXRF_MRM;
        end
      end
    end else if (!req.orig_pcix && req.dest_pcix) begin
      if (req.cmd == pcxrf_pkg::PCXRF_MR) begin
        cmd_next = req.prefetchable ? pcxrf_pkg::PCXRF_MRB : pcxrf_pkg::PCXRF_MRD;
      end
      if (req.cmd == pcxrf_pkg::PCXRF_MRL || req.cmd == pcxrf_pkg::PCXRF_MRM) begin
        cmd_next = pcxrf_pkg::PCXRF_MRB;
      end
    end
    case (req.cmd)
      pcxrf_pkg::PCXRF_MR:  begin
        pf_mode = req.side_sec ? bufctl_reg[`PCXRF_MR_SEC] : bufctl_reg[`PCXRF_MR_PRI];
      end
      pcxrf_pkg::PCXRF_MRL: begin
        pf_mode = req.side_sec ? bufctl_reg[`PCXRF_MRL_SEC] : bufctl_reg[`PCXRF_MRL_PRI];
      end
      default: begin
        pf_mode = req.side_sec ? bufctl_reg[`PCXRF_MRM_SEC] : bufctl_reg[`PCXRF_MRM_PRI];
      end
    endcase
    if (nonpf) begin
      tot_next = `PCXRF_WORD;
    end else if (req.orig_pcix) begin
      tot_next = (span[12:0] + 13'h0003) & 13'h1FFC;
    end else if (pf_mode == `PCXRF_PF_DWORD && req.cmd == pcxrf_pkg::PCXRF_MR) begin
      tot_next = `PCXRF_WORD;
    end else if (pf_mode == `PCXRF_PF_LINE && line_bytes != 10'h000) begin
      tot_next = 13'(line_bytes - {line_off[9:2], 2'h0});
    end else if (pf_mode == `PCXRF_PF_LINE) begin
      tot_next = `PCXRF_WORD;
    end else begin
      // full prefetch capped by byte count field
      tot_next = `PCXRF_MAXB_BASE << bufctl_reg[`PCXRF_MAXB];
    end
  end

  // Size of the next request toward the target
  always_comb begin
    to_mb      = `PCXRF_MB_SPAN - {1'b0, addr_reg[19:0]};
    chunk_next = rem_reg;
    if (dest_pcix_reg && orig_pcix_reg) begin
      if (split_commit < `PCXRF_BIG_COMMIT) begin
        chunk_next = min13(chunk_next, (split_commit >= split_capacity) ?
                                       `PCXRF_BUF_BYTES : lim13(split_commit));
      end
    end else if (dest_pcix_reg) begin
      chunk_next = min13(chunk_next, lim13(split_commit));
      if (to_mb < 21'(chunk_next)) begin
        chunk_next = to_mb[12:0];
      end
    end
    // only what the buffer can hold
    chunk_next = min13(chunk_next, free_bytes);
  end

  assign tgt_take  = tgt_dvalid && tgt_dready;
  assign orig_take = orig_dvalid && orig_dready;

  // Transfer sequencing
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= PCXRF_IDLE;
    end else begin
      case (state_reg)
        PCXRF_IDLE: begin
          if (accept && (hnd_next == pcxrf_pkg::PCXRF_DELAYED ||
                         hnd_next == pcxrf_pkg::PCXRF_SPLIT)) begin
            state_reg <= PCXRF_PLAN;
          end
        end
        PCXRF_PLAN: begin
          state_reg <= PCXRF_ISSUE;
        end
        PCXRF_ISSUE: begin
          if (tgt_req_ready) begin
            state_reg <= PCXRF_FETCH;
          end
        end
        PCXRF_FETCH: begin
          // reissue until count exhausted
          // Done with a stalled word waits, else the word would be stranded
          if (tgt_done && (tgt_take || !tgt_dvalid)) begin
            if (rem_reg == (tgt_take ? `PCXRF_WORD : 13'h0000)) begin
              state_reg <= PCXRF_DRAIN;
            end else begin
              state_reg <= PCXRF_HOLD;
            end
          end
        end
        PCXRF_HOLD: begin
          // resume once a sector is free
          if (free_bytes >= min13(rem_reg, `PCXRF_SECTOR)) begin
            state_reg <= PCXRF_PLAN;
          end
        end
        PCXRF_DRAIN: begin
          if (deliv_reg == 13'h0000) begin
            state_reg <= PCXRF_IDLE;
          end
        end
        default: begin
          state_reg <= PCXRF_IDLE;
        end
      endcase
    end
  end

  // Transaction context
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hnd           <= pcxrf_pkg::PCXRF_DELAYED;
      cmd_reg       <= pcxrf_pkg::PCXRF_MR;
      be_reg        <= `PCXRF_BE_ALL;
      orig_pcix_reg <= 1'b0;
      dest_pcix_reg <= 1'b0;
    end else if (accept) begin
      hnd           <= hnd_next;
      cmd_reg       <= cmd_next;
      be_reg        <= nonpf ? req.be_n : `PCXRF_BE_ALL;
      orig_pcix_reg <= req.orig_pcix;
      dest_pcix_reg <= req.dest_pcix;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hnd_valid <= 1'b0;
    end else begin
      hnd_valid <= accept;
    end
  end

  // Address and remaining count toward the target
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      addr_reg <= 32'h0000_0000;
      rem_reg  <= 13'h0000;
    end else if (accept) begin
      addr_reg <= {req.addr[31:2], 2'h0};
      rem_reg  <= tot_next;
    end else if (tgt_take) begin
      addr_reg <= addr_reg + 32'(`PCXRF_WORD);
      rem_reg  <= rem_reg - `PCXRF_WORD;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      chunk_reg <= 13'h0000;
    end else if (state_reg == PCXRF_PLAN) begin
      chunk_reg <= chunk_next;
    end
  end

  // Bytes held in the read buffer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      credit_reg <= 13'h0000;
    end else begin
      credit_reg <= credit_reg + (tgt_take ? `PCXRF_WORD : 13'h0000)
                               - (orig_take ? `PCXRF_WORD : 13'h0000);
    end
  end

  // Bytes still owed to the originator
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      deliv_reg <= 13'h0000;
    end else if (accept) begin
      deliv_reg <= tot_next;
    end else if (orig_take) begin
      deliv_reg <= deliv_reg - `PCXRF_WORD;
    end
  end

  assign tgt_req_valid = state_reg == PCXRF_ISSUE;
  assign tgt_req.cmd   = cmd_reg;
  assign tgt_req.addr  = addr_reg;
  assign tgt_req.bcnt  = chunk_reg;
  assign tgt_req.be_n  = be_reg;

  assign tgt_stop   = credit_reg >= `PCXRF_BUF_BYTES;
  assign tgt_dready = (state_reg == PCXRF_FETCH) && fifo_in_ready && !tgt_stop;
  // last word ends the initiator transfer
  assign orig_last  = orig_dvalid && (deliv_reg == `PCXRF_WORD);
  // retry a delayed-read initiator until data is held
  assign orig_retry = busy && (hnd == pcxrf_pkg::PCXRF_DELAYED) && !orig_dvalid;

  // Target data staging; a stalled originator backs up into the target bus
  pcxrf_fifo #(
    .WIDTH (`PCXRF_DATA_W),
    .DEPTH (`PCXRF_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (tgt_dvalid && (state_reg == PCXRF_FETCH) && !tgt_stop),
    .in_ready  (fifo_in_ready),
    .in_data   (tgt_data),
    .out_valid (orig_dvalid),
    .out_ready (orig_dready),
    .out_data  (orig_data)
  );
endmodule

/* pcxrf_read_fwd_checker.sv */
// Port-level assertions for the read forwarding block
`timescale 1ns/100ps
module pcxrf_read_fwd_checker (
  input wire logic                     ref_clk,
  input wire logic                     resetn,
  input wire logic                     req_valid,
  input wire logic                     req_ready,
  input wire pcxrf_pkg::pcxrf_req_type req,
  input wire logic                     hnd_valid,
  input wire pcxrf_pkg::pcxrf_hnd_type hnd,
  input wire logic                     tgt_req_valid,
  input wire logic                     tgt_req_ready,
  input wire pcxrf_pkg::pcxrf_tgt_type tgt_req,
  input wire logic                     orig_dvalid,
  input wire logic                     orig_last
);
  logic acc;
  logic imm;
  logic rej;
  assign acc = req_valid && req_ready;
  assign imm = !req.side_sec && req.cmd == pcxrf_pkg::PCXRF_CFG0;
  assign rej = req.side_sec && req.cmd == pcxrf_pkg::PCXRF_CFG1;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  AST_HND_PULSE: assert property (acc |=> hnd_valid ##1 !hnd_valid)
    else $error("handling pulse missing after accept");
  AST_IMMEDIATE: assert property (
    acc && imm |=> hnd == pcxrf_pkg::PCXRF_IMMEDIATE ##0 !tgt_req_valid [*4])
    else $error("type 0 primary read not answered at once");
  AST_REJECT: assert property (
    acc && rej |=> hnd == pcxrf_pkg::PCXRF_REJECT ##0 !tgt_req_valid [*4])
    else $error("type 1 secondary read not refused");
  AST_SPLIT: assert property (
    acc && !imm && !rej && req.orig_pcix |=> hnd == pcxrf_pkg::PCXRF_SPLIT)
    else $error("read from PCI-X origin not split");
  AST_DELAYED: assert property (
    acc && !imm && !rej && !req.orig_pcix |=> hnd == pcxrf_pkg::PCXRF_DELAYED)
    else $error("read from conventional origin not delayed");
  AST_ONE_DWORD: assert property (
    tgt_req_valid && tgt_req.cmd inside {pcxrf_pkg::PCXRF_MRD, pcxrf_pkg::PCXRF_IOR,
      pcxrf_pkg::PCXRF_CFG0, pcxrf_pkg::PCXRF_CFG1} |-> tgt_req.bcnt == 13'h0004)
    else $error("dword read asks for more than one dword");
  AST_PF_ALL_BE: assert property (
    tgt_req_valid && tgt_req.cmd inside {pcxrf_pkg::PCXRF_MRL, pcxrf_pkg::PCXRF_MRM,
      pcxrf_pkg::PCXRF_MRB} |-> tgt_req.be_n == 4'h0)
    else $error("prefetch read without all byte enables");
  AST_REQ_HOLD: assert property (
    tgt_req_valid && !tgt_req_ready |=> tgt_req_valid && $stable(tgt_req))
    else $error("target request dropped or changed before ready");
  AST_LAST_VALID: assert property (orig_last |-> orig_dvalid)
    else $error("last flag without data");
endmodule

/* pcxrf_read_fwd_tb.sv */
// Self-checking bench for the read forwarding block
`timescale 1ns/100ps
module pcxrf_read_fwd_tb;
  typedef struct packed {
    pcxrf_pkg::pcxrf_req_type rq;
    pcxrf_pkg::pcxrf_cmd_type cmd;
    logic [12:0]              bcnt;
    logic [3:0]               be_n;
    logic [1:0]               hnd;
    logic [7:0]               words;
  } pcxrf_row_type;
  localparam pcxrf_pkg::pcxrf_cmd_type MR = pcxrf_pkg::PCXRF_MR, MRL = pcxrf_pkg::PCXRF_MRL;
  localparam pcxrf_pkg::pcxrf_cmd_type MRM = pcxrf_pkg::PCXRF_MRM, MRD = pcxrf_pkg::PCXRF_MRD;
  localparam pcxrf_pkg::pcxrf_cmd_type MRB = pcxrf_pkg::PCXRF_MRB, IOR = pcxrf_pkg::PCXRF_IOR;
  localparam pcxrf_pkg::pcxrf_cmd_type CF0 = pcxrf_pkg::PCXRF_CFG0, CF1 = pcxrf_pkg::PCXRF_CFG1;
  localparam logic [1:0] DLY = pcxrf_pkg::PCXRF_DELAYED, SPL = pcxrf_pkg::PCXRF_SPLIT;
  localparam logic [1:0] IMM = pcxrf_pkg::PCXRF_IMMEDIATE, REJ = pcxrf_pkg::PCXRF_REJECT;
  logic                     ref_clk, resetn, cfg_wr, cfg_rd, req_valid, req_ready, hnd_valid;
  logic [7:0]               cfg_addr, cache_line_dw, disc_words;
  logic [3:0]               cfg_be;
  logic [31:0]              cfg_wdata, cfg_rdata, tgt_data, orig_data, d;
  logic [15:0]              split_capacity, split_commit;
  pcxrf_pkg::pcxrf_req_type req;
  pcxrf_pkg::pcxrf_hnd_type hnd;
  pcxrf_pkg::pcxrf_tgt_type tgt_req;
  pcxrf_pkg::pcxrf_tgt_type tq[$];
  logic                     orig_retry, tgt_req_valid, tgt_req_ready, tgt_dvalid, tgt_dready;
  logic                     tgt_done, tgt_stop, orig_dvalid, orig_dready, orig_last, busy, slow;
  int                       n_mismatch, tests_run, stall;
  pcxrf_row_type rows [16] = '{
    '{'{1'h0,1'h0,1'h0,1'h0,IOR,32'h100,13'h4,4'hA},IOR,13'h4,4'hA,DLY,8'h1},
    '{'{1'h1,1'h1,1'h1,1'h0,IOR,32'h104,13'h4,4'h5},IOR,13'h4,4'h5,SPL,8'h1},
    '{'{1'h0,1'h0,1'h0,1'h0,CF1,32'h201,13'h4,4'h0},CF1,13'h4,4'h0,DLY,8'h1},
    '{'{1'h1,1'h1,1'h0,1'h0,CF0,32'h300,13'h4,4'hC},CF0,13'h4,4'hC,SPL,8'h1},
    '{'{1'h0,1'h1,1'h1,1'h0,CF0,32'h40,13'h4,4'h0},CF0,13'h0,4'h0,IMM,8'h0},
    '{'{1'h1,1'h0,1'h0,1'h0,CF1,32'h201,13'h4,4'h0},CF1,13'h0,4'h0,REJ,8'h0},
    '{'{1'h0,1'h0,1'h0,1'h0,MR,32'h1000,13'h4,4'h3},MR,13'h4,4'h3,DLY,8'h1},
    '{'{1'h0,1'h0,1'h1,1'h0,MR,32'h1004,13'h4,4'h6},MRD,13'h4,4'h6,DLY,8'h1},
    '{'{1'h0,1'h0,1'h1,1'h1,MR,32'h1000,13'h4,4'h0},MRB,13'h20,4'h0,DLY,8'h8},
    '{'{1'h1,1'h0,1'h1,1'h1,MRL,32'h2010,13'h4,4'h0},MRB,13'h10,4'h0,DLY,8'h4},
    '{'{1'h1,1'h0,1'h0,1'h1,MRM,32'h4000,13'h4,4'h0},MRM,13'h200,4'h0,DLY,8'h80},
    '{'{1'h0,1'h1,1'h0,1'h0,MRD,32'h3004,13'h4,4'hE},MR,13'h4,4'hE,SPL,8'h1},
    '{'{1'h0,1'h1,1'h0,1'h1,MRB,32'h3000,13'h4,4'h0},MR,13'h4,4'h0,SPL,8'h1},
    '{'{1'h0,1'h1,1'h0,1'h1,MRB,32'h3000,13'h10,4'h0},MRL,13'h10,4'h0,SPL,8'h4},
    '{'{1'h0,1'h1,1'h0,1'h1,MRB,32'h3010,13'h40,4'h0},MRM,13'h40,4'h0,SPL,8'h10},
    '{'{1'h0,1'h1,1'h1,1'h1,MRB,32'h5000,13'h40,4'h0},MRB,13'h40,4'h0,SPL,8'h10}
  };
  pcxrf_read_fwd u_dut (.*);
  pcxrf_target_model u_tgt (.*);
  always @(posedge ref_clk) if (tgt_req_valid && tgt_req_ready) tq.push_back(tgt_req);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] w);
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = w;
    cfg_wr = 1'h1;
    @(negedge ref_clk);
    cfg_wr = 1'h0;
    @(negedge ref_clk);
  endtask
  task automatic cfg_read(input logic [7:0] a, output logic [31:0] v);
    cfg_addr = a;
    cfg_rd = 1'h1;
    @(negedge ref_clk);
    cfg_rd = 1'h0;
    v = cfg_rdata;
    @(negedge ref_clk);
  endtask
  task automatic do_read(input pcxrf_row_type r);
    int nw;
    // Idle gap keeps accepts apart for the handling checks
    repeat (2) @(negedge ref_clk);
    tq.delete();
    req = r.rq;
    req_valid = 1'h1;
    @(negedge ref_clk);
    req_valid = 1'h0;
    check(hnd_valid, 32'h1);
    check(hnd, r.hnd);
    if (r.hnd == DLY) check(orig_retry, 32'h1);
    nw = 0;
    for (int k = 0; k < 3000 && busy; k++) begin
      orig_dready = (k >= stall);
      if (orig_dvalid && orig_dready) begin
        check(orig_data, {r.rq.addr[31:2], 2'h0} + 32'(nw * 4));
        check(orig_last, 32'(nw + 1 == r.words));
        nw++;
      end
      @(negedge ref_clk);
    end
    check(nw, 32'(r.words));
    if (r.words == 8'h0) check(tq.size(), 32'h0);
    else begin
      check(tq[0].cmd, r.cmd);
      check(tq[0].bcnt, r.bcnt);
      check(tq[0].be_n, r.be_n);
    end
  endtask
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    #(60000 * 50);
    n_mismatch++;
    end_sim();
  end
  initial begin
    {resetn, cfg_wr, cfg_rd, req_valid, slow} = 5'h0;
    {cfg_addr, cfg_be, cfg_wdata, disc_words, stall} = '0;
    req = '0;
    orig_dready = 1'h1;
    cache_line_dw = 8'h08;
    split_capacity = 16'h1000;
    split_commit = 16'h8000;
    repeat (6) @(negedge ref_clk);
    resetn = 1'h1;
    cfg_read(8'h40, d);
    check(d, 32'h0160_2160);
    cfg_read(8'h44, d);
    check(d, 32'h0);
    foreach (rows[i]) do_read(rows[i]);
    cfg_write(8'h40, 4'hF, 32'h0160_1060);
    cfg_write(8'h44, 4'hF, 32'hFFFF_FFFF);
    cfg_read(8'h40, d);
    check(d, 32'h0160_1060);
    // Dword mode and a 256-byte cap, originator stalling
    do_read('{'{1'h0,1'h0,1'h0,1'h1,MR,32'h6000,13'h4,4'h0},MR,13'h4,4'h0,DLY,8'h1});
    stall = 40;
    do_read('{'{1'h0,1'h0,1'h0,1'h1,MRM,32'h6000,13'h4,4'h0},MRM,13'h100,4'h0,DLY,8'h40});
    cfg_write(8'h40, 4'h1, 32'hFFFF_FFFF);
    cfg_read(8'h40, d);
    check(d, 32'h0160_10FF);
    cfg_write(8'h40, 4'hF, 32'h0160_2160);
    // Slow target that disconnects every third word
    stall = 0;
    slow = 1'h1;
    disc_words = 8'h3;
    do_read('{'{1'h0,1'h1,1'h0,1'h1,MRB,32'h3010,13'h40,4'h0},MRM,13'h40,4'h0,SPL,8'h10});
    check(tq.size(), 32'h6);
    slow = 1'h0;
    disc_words = 8'h0;
    stall = 150;
    do_read('{'{1'h0,1'h0,1'h1,1'h1,MRM,32'hF_FFF0,13'h4,4'h0},MRB,13'h10,4'h0,DLY,8'h80});
    check(tq[1].addr, 32'h0010_0000);
    // Mid-run reset must restore the buffering control defaults
    cfg_write(8'h40, 4'hF, 32'h0000_0000);
    resetn = 1'h0;
    @(negedge ref_clk);
    check(busy, 32'h0);
    resetn = 1'h1;
    cfg_read(8'h40, d);
    check(d, 32'h0160_2160);
    end_sim();
  end
endmodule
bind pcxrf_read_fwd pcxrf_read_fwd_checker u_chk (.*);

/* pcxrf_target_model.sv */
// Target-side bus agent: accepts fetch requests and returns address-valued words
`timescale 1ns/100ps
module pcxrf_target_model (
  input wire logic                     ref_clk,
  input wire logic                     resetn,
  input wire logic                     slow,
  input wire logic [7:0]               disc_words,
  input wire logic                     tgt_req_valid,
  output logic                         tgt_req_ready,
  input wire pcxrf_pkg::pcxrf_tgt_type tgt_req,
  output logic                         tgt_dvalid,
  input wire logic                     tgt_dready,
  output logic [31:0]                  tgt_data,
  output logic                         tgt_done
);
  logic [12:0] left_reg;
  logic [31:0] addr_reg;
  logic [7:0]  cnt_reg;
  logic        gap_reg;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tgt_req_ready <= 1'h0;
      tgt_dvalid <= 1'h0;
      tgt_done <= 1'h0;
      tgt_data <= 32'h0;
      left_reg <= 13'h0;
      addr_reg <= 32'h0;
      cnt_reg <= 8'h0;
      gap_reg <= 1'h0;
    end else begin
      tgt_req_ready <= tgt_req_valid && !tgt_req_ready && left_reg == 13'h0 && !tgt_dvalid;
      if (tgt_req_valid && tgt_req_ready) begin
        left_reg <= tgt_req.bcnt;
        addr_reg <= tgt_req.addr;
        cnt_reg <= 8'h0;
      end else if (tgt_dvalid) begin
        if (tgt_dready) begin
          tgt_dvalid <= 1'h0;
          tgt_done <= 1'h0;
          // Released data lines must not keep the last word
          tgt_data <= ~tgt_data;
          left_reg <= tgt_done ? 13'h0 : left_reg - 13'h4;
          addr_reg <= addr_reg + 32'h4;
          cnt_reg <= cnt_reg + 8'h1;
          gap_reg <= slow;
        end
      end else if (left_reg != 13'h0 && !gap_reg) begin
        tgt_dvalid <= 1'h1;
        tgt_data <= addr_reg;
        tgt_done <= left_reg == 13'h4 || cnt_reg + 8'h1 == disc_words;
      end else begin
        gap_reg <= 1'h0;
      end
    end
  end
endmodule
